// *** line_pulse_shaper_range_ctl.sv ***
// Purpose: staircase pulse shaper and receive range control for one line port
// Assumes: symbols from same-clock logic; control levels arrive from pins
// Notes: output is a signed level code in sixteenths; negative pin carries its negation
// Operation
// - range bit one attenuates receive by 6 dB while powered up, zero or power down gives none
// - each symbol yields one pulse of exactly 24 steps
// - step period 0.78 us quaternary, 0.52 us ternary
// - new pulse every 16 steps: 80 kHz or 120 kHz symbol rate
// - successive pulses overlap by 8 steps
// - rising levels 0 then 1/16 rising by 2/16 to 15/16
// - level full after steps 9 through 16
// - falling levels 15/16 down to 1/16, then zero from 25
// - magnitude one pulse is a third of magnitude three
// - negative symbols give exact negated pulses
// - quaternary takes +3 +1 -1 -3, ternary takes +1 0 -1
// - output hold updates once per step period
// - sampling switch closed a third of each period, rounded up: 4 of 12 or 3 of 8 master ticks
// - all timing comes from the 15.36 MHz master clock
// - power down disables output drive and grounds both pins
// - reset clears receive attenuation
`timescale 1ns/10ps
`include "line_pulse_shaper_params.svh"
module line_pulse_shaper_range_ctl #(
    parameter int OUT_W = 8,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ternaryMode,
    input wire logic rangeCtl,
    input wire logic powerDownCtl,
    input wire logic [2:0] symData,
    input wire logic symValid,
    output logic symReady,
    output logic [OUT_W-1:0] lineOutPos,
    output logic [OUT_W-1:0] lineOutNeg,
    output logic lineDriveEn,
    output logic sampleSwitch,
    output logic rxAtten,
    output logic symbolError
);
    // pin synchronisers: ternary, range, power down
    logic [2:0] syncA_q, syncB_q, syncC_q, ctl_q;
    wire [2:0] ctlPins = {powerDownCtl, rangeCtl, ternaryMode};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    syncA_q[g] <= 1'b0;
                    syncB_q[g] <= 1'b0;
                    syncC_q[g] <= 1'b0;
                    ctl_q[g] <= 1'b0;
                end else begin
                    syncA_q[g] <= ctlPins[g];
                    syncB_q[g] <= syncA_q[g];
                    syncC_q[g] <= syncB_q[g];
                    if (syncB_q[g] == syncC_q[g]) ctl_q[g] <= syncC_q[g];
                end
            end
        end
    endgenerate

    wire ternary = ctl_q[0];
    wire rangeOn = ctl_q[1];
    wire powerDown = ctl_q[2];
    line_pulse_shaper_pkg::line_code_type lineCode;
    assign lineCode = ternary ? line_pulse_shaper_pkg::LINE_TERN : line_pulse_shaper_pkg::LINE_QUAT;

    // port power state
    line_pulse_shaper_pkg::port_state_type state_q, state_d;
    always_comb begin
        case (state_q)
            line_pulse_shaper_pkg::PORT_DOWN: state_d = powerDown ? line_pulse_shaper_pkg::PORT_DOWN
                                                                  : line_pulse_shaper_pkg::PORT_UP;
            line_pulse_shaper_pkg::PORT_UP: state_d = powerDown ? line_pulse_shaper_pkg::PORT_DOWN
                                                                : line_pulse_shaper_pkg::PORT_UP;
            default: state_d = line_pulse_shaper_pkg::PORT_DOWN;
        endcase
    end
    wire portUp = (state_q == line_pulse_shaper_pkg::PORT_UP);

    // timing
    logic stepTick, switchClosed;
    step_timer u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ternary(lineCode == line_pulse_shaper_pkg::LINE_TERN),
        .stepTick(stepTick),
        .switchClosed(switchClosed)
    );

    // symbol buffer; popped only at pulse starts, so a slow shaper pushes back on the source
    symbol_if #(.WIDTH(3)) symIf ();
    symbol_buffer #(.WIDTH(3), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .inValid(symValid),
        .inData(symData),
        .inReady(symReady),
        .outIf(symIf)
    );

    logic [3:0] phase_q;
    logic slotSel_q;
    wire loadNow = portUp && stepTick && (phase_q == 4'(`LPS_PULSE_SPACING - 1));
    assign symIf.ready = loadNow;

    // legal symbol check
    line_pulse_shaper_pkg::symbol_type inSym;
    assign inSym = line_pulse_shaper_pkg::symbol_type'(symIf.data);
    wire quatLegal = (inSym == 3'sd3) || (inSym == 3'sd1) || (inSym == -3'sd1) || (inSym == -3'sd3);
    wire ternLegal = (inSym == 3'sd1) || (inSym == 3'sd0) || (inSym == -3'sd1);
    wire symLegal = ternary ? ternLegal : quatLegal;
    wire takeSym = loadNow && symIf.valid;
    // an illegal or missing symbol sends a zero pulse so the line keeps its timing
    line_pulse_shaper_pkg::symbol_type newSym;
    assign newSym = (takeSym && symLegal) ? inSym : 3'sd0;

    // pulse shape, sixteenths
    function automatic logic [4:0] shapeLevel(input logic [4:0] age);
        logic [4:0] lvl;
        lvl = 5'h00;
        if (age == 5'h00 || age >= `LPS_AGE_END) lvl = 5'h00;
        else if (age <= 5'(`LPS_RISE_END)) lvl = 5'((age << 1) - 5'h01);
        else if (age <= 5'(`LPS_FLAT_END)) lvl = `LPS_LEVEL_FULL;
        else lvl = 5'(6'h31 - {age, 1'b0});
        return lvl;
    endfunction : shapeLevel

    // two slots cover the 8-step overlap of neighbouring pulses
    line_pulse_shaper_pkg::symbol_type slotSym_q [2];
    logic [4:0] slotAge_q [2];
    logic signed [8:0] contrib [2];
    logic [4:0] slotLvl [2];

    generate
        for (g = 0; g < 2; g++) begin : g_slot
            assign slotLvl[g] = shapeLevel(slotAge_q[g]);
            assign contrib[g] = slotSym_q[g] * $signed({1'b0, slotLvl[g]});
            always_ff @(posedge clk_sys) begin
                if (!resetn || !portUp) begin
                    slotSym_q[g] <= 3'sd0;
                    slotAge_q[g] <= `LPS_AGE_RESET;
                end else if (stepTick) begin
                    if (loadNow && (slotSel_q == 1'(g))) begin
                        slotSym_q[g] <= newSym;
                        slotAge_q[g] <= 5'h00;
                    end else if (slotAge_q[g] < `LPS_AGE_END) begin
                        slotAge_q[g] <= slotAge_q[g] + 5'h01;
                    end
                end
            end
        end
    endgenerate

    wire signed [9:0] levelSum = 10'(contrib[0]) + 10'(contrib[1]);

    logic [OUT_W-1:0] lineOutPos_q, lineOutNeg_q;
    logic lineDriveEn_q, sampleSwitch_q, rxAtten_q, symbolError_q;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= line_pulse_shaper_pkg::PORT_DOWN;
            phase_q <= 4'h0;
            slotSel_q <= 1'b0;
            rxAtten_q <= 1'b0;
            symbolError_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (!portUp) phase_q <= 4'h0;
            else if (stepTick) phase_q <= phase_q + 4'h1;
            if (!portUp) slotSel_q <= 1'b0;
            else if (loadNow) slotSel_q <= !slotSel_q;
            rxAtten_q <= rangeOn && !powerDown;
            symbolError_q <= takeSym && !symLegal;
        end
    end

    // output hold: refreshed once per step, grounded while powered down
    always_ff @(posedge clk_sys) begin
        if (!resetn || !portUp || powerDown) begin
            lineOutPos_q <= `LPS_OUT_RESET;
            lineOutNeg_q <= `LPS_OUT_RESET;
            lineDriveEn_q <= 1'b0;
            sampleSwitch_q <= 1'b0;
        end else begin
            if (stepTick) begin
                lineOutPos_q <= OUT_W'(levelSum);
                lineOutNeg_q <= OUT_W'(-levelSum);
            end
            lineDriveEn_q <= 1'b1;
            sampleSwitch_q <= switchClosed;
        end
    end

    assign lineOutPos = lineOutPos_q;
    assign lineOutNeg = lineOutNeg_q;
    assign lineDriveEn = lineDriveEn_q;
    assign sampleSwitch = sampleSwitch_q;
    assign rxAtten = rxAtten_q;
    assign symbolError = symbolError_q;

    // helper counters for the checks
    logic [5:0] stepsSinceLoad_q;
    logic [5:0] clksSinceStep_q;
    logic seenLoad_q, seenStep_q;
    logic ternaryPrev_q;
    always_ff @(posedge clk_sys) begin
        if (!resetn || !portUp) begin
            stepsSinceLoad_q <= 6'h00;
            clksSinceStep_q <= 6'h00;
            seenLoad_q <= 1'b0;
            seenStep_q <= 1'b0;
            ternaryPrev_q <= 1'b0;
        end else begin
            if (loadNow) stepsSinceLoad_q <= 6'h01;
            else if (stepTick) stepsSinceLoad_q <= stepsSinceLoad_q + 6'h01;
            if (loadNow) seenLoad_q <= 1'b1;
            clksSinceStep_q <= stepTick ? 6'h01 : clksSinceStep_q + 6'h01;
            ternaryPrev_q <= ternary;
            // a step that spans a mode change has a mixed length, so skip its check
            if (ternary != ternaryPrev_q) seenStep_q <= 1'b0;
            else if (stepTick) seenStep_q <= 1'b1;
        end
    end

    property p_range_atten;
        @(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> (rxAtten_q == $past(rangeOn && !powerDown));
    endproperty
    a_range_atten: assert property (p_range_atten) else $error("range bit set but no attenuation");

    property p_reset_atten;
        @(posedge clk_sys) !resetn |=> !rxAtten_q;
    endproperty
    a_reset_atten: assert property (p_reset_atten) else $error("attenuation survives reset");

    property p_pulse_spacing;
        @(posedge clk_sys) disable iff (!resetn || !portUp)
        (loadNow && seenLoad_q) |-> (stepsSinceLoad_q == 6'(`LPS_PULSE_SPACING));
    endproperty
    a_pulse_spacing: assert property (p_pulse_spacing) else $error("pulse start not 16 steps apart");

    property p_step_period;
        @(posedge clk_sys) disable iff (!resetn || !portUp)
        (stepTick && seenStep_q && $stable(ternary)) |->
            (ternary ? (clksSinceStep_q >= 6'd13 && clksSinceStep_q <= 6'd14)
                     : (clksSinceStep_q >= 6'd19 && clksSinceStep_q <= 6'd20));
    endproperty
    a_step_period: assert property (p_step_period) else $error("step period off");

    property p_power_down;
        @(posedge clk_sys) disable iff (!resetn)
        powerDown |=> (lineOutPos_q == '0 && lineOutNeg_q == '0 && !lineDriveEn_q);
    endproperty
    a_power_down: assert property (p_power_down) else $error("line driven while powered down");

    property p_hold;
        @(posedge clk_sys) disable iff (!resetn || !portUp || powerDown)
        !stepTick |=> $stable(lineOutPos_q);
    endproperty
    a_hold: assert property (p_hold) else $error("output changed between steps");

    property p_pulse_length;
        @(posedge clk_sys) disable iff (!resetn)
        (slotAge_q[0] >= `LPS_AGE_END) ? (contrib[0] == 9'sd0)
                                        : ((slotAge_q[0] != 5'h18) || (slotLvl[0] == 5'h01));
    endproperty
    a_pulse_length: assert property (p_pulse_length) else $error("pulse outlives 24 steps");

    property p_switch;
        @(posedge clk_sys) disable iff (!resetn || !portUp || powerDown)
        stepTick |=> ##1 sampleSwitch_q ##1 sampleSwitch_q;
    endproperty
    a_switch: assert property (p_switch) else $error("sampling switch not closed after step");

    property p_illegal;
        @(posedge clk_sys) disable iff (!resetn)
        (takeSym && ternary && (inSym == 3'sd3)) |=> symbolError_q ##1 !symbolError_q;
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal ternary symbol not flagged");

    property p_symmetry;
        @(posedge clk_sys) disable iff (!resetn)
        stepTick && portUp && !powerDown |=> (lineOutNeg_q == OUT_W'(-$signed(lineOutPos_q)));
    endproperty
    a_symmetry: assert property (p_symmetry) else $error("negative line not mirror of positive");

    property p_switch_open;
        @(posedge clk_sys) disable iff (!resetn || !portUp || powerDown)
        stepTick |-> !sampleSwitch_q;
    endproperty
    a_switch_open: assert property (p_switch_open) else $error("sampling switch still closed at next step");

    property p_quat_illegal;
        @(posedge clk_sys) disable iff (!resetn)
        (takeSym && !ternary && (inSym == 3'sd0)) |=> symbolError_q;
    endproperty
    a_quat_illegal: assert property (p_quat_illegal) else $error("zero symbol in quaternary not flagged");
endmodule : line_pulse_shaper_range_ctl

// *** line_pulse_shaper_params.svh ***
// Purpose: constants of the line pulse shaper and range control
// Assumes: clk_sys at 25 MHz stands in for the 15.36 MHz master clock via a fractional tick
// Notes: definitions only
`ifndef LINE_PULSE_SHAPER_PARAMS_SVH
`define LINE_PULSE_SHAPER_PARAMS_SVH

// master tick rate over clk_sys rate, reduced: 15360 / 25000 = 384 / 625
`define LPS_CLK_KHZ 25000
`define LPS_MASTER_KHZ 15360
`define LPS_FRAC_INC 11'h180
`define LPS_FRAC_MOD 11'h271

// step periods in ns, and master ticks per step rounded to nearest
`define LPS_STEP_QUAT_NS 780
`define LPS_STEP_TERN_NS 520
`define LPS_DIV_QUAT ((`LPS_STEP_QUAT_NS * `LPS_MASTER_KHZ + 500000) / 1000000)
`define LPS_DIV_TERN ((`LPS_STEP_TERN_NS * `LPS_MASTER_KHZ + 500000) / 1000000)
// switch closed for a third of the step, rounded up
`define LPS_CLOSE_QUAT ((`LPS_DIV_QUAT + 2) / 3)
`define LPS_CLOSE_TERN ((`LPS_DIV_TERN + 2) / 3)

// pulse shape, levels in sixteenths of full amplitude
`define LPS_PULSE_STEPS 24
`define LPS_PULSE_SPACING 16
`define LPS_OVERLAP_STEPS 8
`define LPS_RISE_END 8
`define LPS_FLAT_END 16
`define LPS_AGE_END 5'h19
`define LPS_LEVEL_FULL 5'h10
`define LPS_SYNC_DEPTH 3

// reset values
`define LPS_OUT_RESET 8'h00
`define LPS_AGE_RESET 5'h19

`endif

// *** line_pulse_shaper_pkg.sv ***
// Purpose: types of the line pulse shaper
// Assumes: nothing
// Notes: constants live in the params header
package line_pulse_shaper_pkg;
    typedef logic signed [2:0] symbol_type;
    typedef enum logic {LINE_QUAT, LINE_TERN} line_code_type;
    typedef enum logic [1:0] {PORT_DOWN, PORT_UP} port_state_type;
endpackage : line_pulse_shaper_pkg

// *** symbol_if.sv ***
// Purpose: valid/ready symbol carrier between buffer and shaper
// Assumes: one clock
// Notes: data taken when valid and ready are both high
`timescale 1ns/10ps
interface symbol_if #(parameter int WIDTH = 3);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface : symbol_if

// *** symbol_buffer.sv ***
// Purpose: two-entry symbol buffer so a stalled shaper loses no symbol
// Assumes: source and sink on clk_sys
// Notes: inReady comes from a flop
`timescale 1ns/10ps
module symbol_buffer #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    symbol_if.source outIf
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q, rdPtr_q;
    logic [AW:0] count_q, count_d;
    logic inReady_q;
    wire push = inValid && inReady_q;
    wire pop = outIf.valid && outIf.ready;

    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign inReady = inReady_q;
    assign outIf.valid = (count_q != '0);
    assign outIf.data = mem[rdPtr_q];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            inReady_q <= 1'b0;
        end else begin
            if (push) wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            if (pop) rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            count_q <= count_d;
            inReady_q <= (count_d != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) mem[wrPtr_q] <= inData;
    end

    property p_no_overflow;
        @(posedge clk_sys) disable iff (!resetn)
        count_q <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("symbol buffer overflow");
endmodule : symbol_buffer

// *** step_timer.sv ***
// Purpose: master tick, step tick and sampling switch window
// Assumes: clk_sys 25 MHz
// Notes: master ticks jitter by one clk_sys cycle, step length averages exactly
`timescale 1ns/10ps
`include "line_pulse_shaper_params.svh"
module step_timer (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ternary,
    output logic stepTick,
    output logic switchClosed
);
    localparam logic [3:0] DIV_Q = 4'(`LPS_DIV_QUAT);
    localparam logic [3:0] DIV_T = 4'(`LPS_DIV_TERN);
    localparam logic [3:0] CLOSE_Q = 4'(`LPS_CLOSE_QUAT);
    localparam logic [3:0] CLOSE_T = 4'(`LPS_CLOSE_TERN);
    logic [10:0] acc_q;
    logic [3:0] div_q;
    logic stepTick_q, switchClosed_q;
    wire [10:0] accSum = acc_q + `LPS_FRAC_INC;
    wire masterTick = (accSum >= `LPS_FRAC_MOD);
    wire [3:0] divLast = ternary ? DIV_T - 4'h1 : DIV_Q - 4'h1;
    wire [3:0] closeCnt = ternary ? CLOSE_T : CLOSE_Q;
    wire stepEnd = masterTick && (div_q >= divLast);

    assign stepTick = stepTick_q;
    assign switchClosed = switchClosed_q;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            acc_q <= 11'h000;
            div_q <= 4'h0;
            stepTick_q <= 1'b0;
            switchClosed_q <= 1'b0;
        end else begin
            acc_q <= masterTick ? accSum - `LPS_FRAC_MOD : accSum;
            if (masterTick) div_q <= stepEnd ? 4'h0 : div_q + 4'h1;
            stepTick_q <= stepEnd;
            // >= so a mode change inside the closed window still opens the switch
            switchClosed_q <= stepEnd || (switchClosed_q && !(masterTick && div_q >= closeCnt - 4'h1));
        end
    end
endmodule : step_timer

// *** transceiver_model.sv ***
// Purpose: far-side transceiver model feeding symbols and the range bit
// Assumes: bench loads symbols into pending; driven at falling edge
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/10ps
module transceiver_model (
    input wire logic clk_sys,
    input wire logic symReady,
    input wire logic rangeReq,
    output logic rangeCtl,
    output logic symValid,
    output logic [2:0] symData
);
    logic [2:0] pending[$];
    logic taken = 1'b0;
    initial begin
        symValid = 1'b0;
        symData = 3'h0;
    end
    // range bit raised on request, as on short loops
    assign rangeCtl = rangeReq;
    always @(posedge clk_sys) begin
        taken <= symValid && symReady;
    end
    // offer held until a rising edge sees ready high
    always @(negedge clk_sys) begin
        if (taken && pending.size() > 0) begin
            void'(pending.pop_front());
        end
        if (pending.size() > 0) begin
            symValid = 1'b1;
            symData = pending[0];
        end else begin
            symValid = 1'b0;
            symData = ~symData;
        end
    end
endmodule : transceiver_model

// *** line_pulse_shaper_range_ctl_tb.sv ***
// Purpose: self-checking bench of the line pulse shaper and range control
// Assumes: 25 MHz clk_sys, inputs changed at falling edge
// Notes: steps are found by the rising edge of sampleSwitch
`timescale 1ns/10ps
module line_pulse_shaper_range_ctl_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ternaryMode = 1'b0;
    logic powerDownCtl = 1'b0;
    logic rangeReq = 1'b0;
    logic rangeCtl;
    logic symValid;
    logic symReady;
    logic [2:0] symData;
    logic [7:0] lineOutPos;
    logic [7:0] lineOutNeg;
    logic lineDriveEn;
    logic sampleSwitch;
    logic rxAtten;
    logic symbolError;
    int n_errors = 0;
    int tests_run = 0;
    always #20 clk_sys = ~clk_sys;
    line_pulse_shaper_range_ctl u_dut (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ternaryMode(ternaryMode),
        .rangeCtl(rangeCtl),
        .powerDownCtl(powerDownCtl),
        .symData(symData),
        .symValid(symValid),
        .symReady(symReady),
        .lineOutPos(lineOutPos),
        .lineOutNeg(lineOutNeg),
        .lineDriveEn(lineDriveEn),
        .sampleSwitch(sampleSwitch),
        .rxAtten(rxAtten),
        .symbolError(symbolError)
    );
    transceiver_model u_far (
        .clk_sys(clk_sys),
        .symReady(symReady),
        .rangeReq(rangeReq),
        .rangeCtl(rangeCtl),
        .symValid(symValid),
        .symData(symData)
    );
    task automatic complete_run();
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic check1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check1
    task automatic fail_wait();
        n_errors++;
        complete_run();
    endtask : fail_wait
    // relative level in sixteenths of step k of one unit pulse
    function automatic int lev(input int k);
        if (k < 1 || k > 24) return 0;
        if (k <= 8) return 2 * k - 1;
        if (k <= 16) return 16;
        return 2 * (25 - k) - 1;
    endfunction : lev
    // called where sampleSwitch just rose; returns period and closed time
    task automatic next_step(output int per, output int hi);
        per = 0;
        hi = 0;
        while (sampleSwitch === 1'b1) begin
            @(negedge clk_sys);
            per++;
            hi++;
            if (hi > 40) fail_wait();
        end
        while (sampleSwitch !== 1'b1) begin
            @(negedge clk_sys);
            per++;
            if (per > 60) fail_wait();
        end
    endtask : next_step
    task automatic wait_pulse();
        int per;
        int hi;
        int k;
        k = 0;
        while (lineOutPos === 8'h00 && k < 40) begin
            next_step(per, hi);
            k++;
        end
        if (lineOutPos === 8'h00) fail_wait();
    endtask : wait_pulse
    task automatic do_reset();
        resetn = 1'b0;
        repeat (3) @(negedge clk_sys);
        check8(lineOutPos, 8'h00);
        check1(lineDriveEn, 1'b0);
        check1(rxAtten, 1'b0);
        check1(symReady, 1'b0);
        resetn = 1'b1;
        @(negedge clk_sys);
        check1(symReady, 1'b1);
        repeat (10) @(negedge clk_sys);
    endtask : do_reset
    // back-to-back symbols: overlapping staircases summed step by step
    task automatic play(input logic tern, input line_pulse_shaper_pkg::symbol_type syms[4], input int n);
        int per;
        int hi;
        int tot;
        int k;
        int e;
        int i;
        ternaryMode = tern;
        repeat (20) @(negedge clk_sys);
        // fill just after a step edge so no pulse start falls in the fill window
        next_step(per, hi);
        for (i = 0; i < n; i++) begin
            u_far.pending.push_back(syms[i]);
        end
        repeat (5) @(negedge clk_sys);
        check1(symReady, 1'b0); // a full buffer holds the third symbol back
        wait_pulse();
        tot = 0;
        for (k = 1; k <= 16 * (n - 1) + 25; k++) begin
            if (k > 1) begin
                next_step(per, hi);
                if (k <= 25) tot += per;
                check1(logic'(tern ? per inside {[13:14]} : per inside {[19:20]}), 1'b1);
                check1(logic'(tern ? hi inside {[4:5]} : hi inside {[6:7]}), 1'b1);
            end
            e = 0;
            for (i = 0; i < n; i++) begin
                e += int'(syms[i]) * lev(k - 16 * i);
            end
            check8(lineOutPos, 8'(e));
            check8(lineOutNeg, 8'(-e));
            check1(lineDriveEn, 1'b1);
        end
        // 24 step periods of the first pulse, averaged over master ticks
        check1(logic'(tern ? tot inside {[312:313]} : tot inside {[468:469]}), 1'b1);
    endtask : play
    task automatic bad_symbol();
        int c;
        logic seen;
        logic moved;
        seen = 1'b0;
        moved = 1'b0;
        u_far.pending.push_back(3'h3);
        for (c = 0; c < 700; c++) begin
            @(negedge clk_sys);
            if (symbolError === 1'b1) seen = 1'b1;
            if (lineOutPos !== 8'h00) moved = 1'b1;
        end
        check1(seen, 1'b1);
        check1(moved, 1'b0);
    endtask : bad_symbol
    task automatic range_power();
        rangeReq = 1'b1;
        repeat (4) @(negedge clk_sys);
        check1(rxAtten, 1'b0);
        repeat (2) @(negedge clk_sys);
        check1(rxAtten, 1'b1);
        ternaryMode = 1'b0;
        u_far.pending.push_back(3'h0);
        u_far.pending.push_back(3'h3);
        wait_pulse();
        powerDownCtl = 1'b1;
        repeat (8) @(negedge clk_sys);
        check8(lineOutPos, 8'h00);
        check8(lineOutNeg, 8'h00);
        check1(lineDriveEn, 1'b0);
        check1(rxAtten, 1'b0);
        powerDownCtl = 1'b0;
        repeat (10) @(negedge clk_sys);
        check1(lineDriveEn, 1'b1);
        check1(rxAtten, 1'b1);
        do_reset();
        rangeReq = 1'b0;
    endtask : range_power
    initial begin
        line_pulse_shaper_pkg::symbol_type quat[4];
        line_pulse_shaper_pkg::symbol_type tern[4];
        quat = '{3'sh3, 3'sh1, -3'sh1, -3'sh3};
        tern = '{3'sh1, 3'sh0, -3'sh1, 3'sh0};
        do_reset();
        play(1'b0, quat, 4);
        play(1'b1, tern, 3);
        bad_symbol();
        range_power();
        complete_run();
    end
endmodule : line_pulse_shaper_range_ctl_tb
